// File: rtl/uss_core.sv
/*
  Universal serial shift core: shift data register with output latch,
  receive buffer, 4-bit edge counter, status flags and start/stop detection.
  Assumes an Avalon-MM master with waitrequest, open-drain pad logic outside,
  a timer compare-match pulse on the system clock, and a port direction bit.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module uss_core (
  // Clock and reset.
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // Avalon-MM slave.
  input wire logic [uss_pkg::USS_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [uss_pkg::USS_DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [uss_pkg::USS_DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Serial pins.
  input wire logic SERIAL_IN_PIN_IN,
  input wire logic SERIAL_CLOCK_PIN_IN,
  output logic DATA_OUT_PIN_OUT,
  output logic DATA_OUT_OE_OUT,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  // Neighbouring logic.
  input wire logic TIMER_MATCH_IN,
  input wire logic DATA_DIR_IN,
  // Interrupt requests and wake-up.
  output logic START_IRQ_OUT,
  output logic WRAP_IRQ_OUT,
  output logic WAKE_ALL_OUT,
  output logic WAKE_IDLE_OUT
);
  import uss_pkg::*;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // A flag update in which a set in the same cycle beats the clear.
  function automatic logic flag_upd(input logic old, input logic set, input logic clr);
    flag_upd = set | (old & ~clr);
  endfunction : flag_upd

  // ****************************************************************
  // State.
  // ****************************************************************
  uss_state_t s_reg;
  uss_state_t s_next;

  logic scl;
  logic sda;
  logic ext_rise;
  logic ext_fall;
  logic dly_fell;
  logic dly_rose;
  logic two_wire;
  logic start_det;
  logic stop_det;
  logic accept;
  logic wr_go;
  logic [5:0] idx;
  logic wr_ctl;
  logic wr_sts;
  logic wr_dat;
  logic [7:0] wbyte;
  logic strobe_clk;
  logic strobe_tc;
  logic shift_tick;
  logic count_tick;
  logic wrap;
  logic start_set;
  logic transparent;
  logic [7:0] status_rd;
  logic [7:0] ctl_rd;

  always_comb begin
    s_next = s_reg;
    // ****************************************************************
    // Pin synchronisers and edge finding.
    // ****************************************************************
    s_next.scl_sync = {s_reg.scl_sync[0], SERIAL_CLOCK_PIN_IN};
    s_next.sda_sync = {s_reg.sda_sync[0], SERIAL_IN_PIN_IN};
    s_next.scl_prev = s_reg.scl_sync[1];
    s_next.sda_dly = {s_reg.sda_dly[USS_SDA_DELAY_CYC-1:0], s_reg.sda_sync[1]};
    scl = s_reg.scl_sync[1];
    sda = s_reg.sda_sync[1];
    ext_rise = scl & ~s_reg.scl_prev;
    ext_fall = ~scl & s_reg.scl_prev;

    // ****************************************************************
    // Start and stop detection.
    // ****************************************************************
    // The clock line is sampled against the delayed data line.
    dly_fell = ~s_reg.sda_dly[USS_SDA_DELAY_CYC-1] & s_reg.sda_dly[USS_SDA_DELAY_CYC];
    dly_rose = s_reg.sda_dly[USS_SDA_DELAY_CYC-1] & ~s_reg.sda_dly[USS_SDA_DELAY_CYC];
    two_wire = s_reg.ctl.mode[1];
    // Detection looks at the pins and is enabled only in the two-wire modes (mode[1] set).
    start_det = two_wire & scl & dly_fell;
    stop_det = two_wire & scl & dly_rose;

    // ****************************************************************
    // Bus slave.
    // ****************************************************************
    accept = (AVS_READ_IN | AVS_WRITE_IN) & s_reg.wait_r;
    s_next.wait_r = ~accept;
    wr_go = AVS_WRITE_IN & ~s_reg.wait_r & AVS_BYTEENABLE_IN[0];
    idx = AVS_ADDRESS_IN[7:2];
    wbyte = AVS_WRITEDATA_IN[7:0];
    wr_ctl = wr_go & (idx == USS_IDX_CONTROL);
    wr_sts = wr_go & (idx == USS_IDX_STATUS);
    wr_dat = wr_go & (idx == USS_IDX_SHIFT);
    strobe_clk = wr_ctl & wbyte[USS_CTL_SHIFT_STB];
    strobe_tc = wr_ctl & wbyte[USS_CTL_TOGGLE_STB];
    if (wr_ctl) begin
      s_next.ctl = wbyte[USS_CTL_START_IE:USS_CTL_CSEL_LO];
      s_next.tc_count = wbyte[USS_CTL_SHIFT_STB];
    end

    // ****************************************************************
    // Clock source selection.
    // ****************************************************************
    unique case (s_next.ctl.csel)
      USS_CSEL_SOFT: shift_tick = strobe_clk;
      USS_CSEL_TIMER: shift_tick = TIMER_MATCH_IN;
      USS_CSEL_EXT_RISE: shift_tick = ext_rise;
      USS_CSEL_EXT_FALL: shift_tick = ext_fall;
    endcase
    if (s_next.ctl.csel[1]) begin
      // Both pin edges count, or toggle strobes when so chosen.
      count_tick = s_next.tc_count ? strobe_tc : (ext_rise | ext_fall);
    end else begin
      // Software strobe or timer match, which chains the two counters.
      count_tick = shift_tick;
    end

    // ****************************************************************
    // Counter.
    // ****************************************************************
    wrap = count_tick & (s_reg.cnt == USS_CNT_MAX);
    if (wr_sts) begin
      s_next.cnt = wbyte[3:0];
    end else if (count_tick) begin
      s_next.cnt = s_reg.cnt + 4'h1;
    end

    // ****************************************************************
    // Shift data register and receive buffer.
    // ****************************************************************
    if (wr_dat) begin
      s_next.shift = wbyte;
    end else if (shift_tick) begin
      s_next.shift = {s_reg.shift[6:0], sda};
    end
    if (wrap) begin
      s_next.rxbuf = s_next.shift;
    end

    // ****************************************************************
    // Status flags.
    // ****************************************************************
    if (two_wire) begin
      start_set = start_det;
    end else begin
      start_set = s_next.ctl.csel[1] & ~s_next.tc_count & (ext_rise | ext_fall);
    end
    s_next.start_f = flag_upd(s_reg.start_f, start_set, wr_sts & wbyte[USS_STS_START]);
    s_next.wrap_f = flag_upd(s_reg.wrap_f, wrap, wr_sts & wbyte[USS_STS_WRAP]);
    s_next.stop_f = flag_upd(s_reg.stop_f, stop_det, wr_sts & wbyte[USS_STS_STOP]);

    // ****************************************************************
    // Clock hold.
    // ****************************************************************
    if (~s_next.start_f | ~two_wire) begin
      s_next.start_hold = 1'b0;
    end else if (ext_fall) begin
      s_next.start_hold = 1'b1;
    end
    s_next.scl_oe = two_wire & (s_next.start_hold | ((s_next.ctl.mode == USS_MODE_TWO_HOLD) & s_next.wrap_f));

    // ****************************************************************
    // Output latch and pins.
    // ****************************************************************
    if (~s_next.ctl.csel[1]) begin
      transparent = 1'b1;
    end else if (s_next.ctl.csel == USS_CSEL_EXT_RISE) begin
      transparent = ~scl;
    end else begin
      transparent = scl;
    end
    if (transparent) begin
      s_next.out_latch = s_next.shift[7];
    end
    s_next.do_o = s_next.out_latch;
    s_next.do_oe = (s_next.ctl.mode == USS_MODE_THREE) & DATA_DIR_IN;
    s_next.sda_oe = two_wire & DATA_DIR_IN & ~s_next.out_latch;

    // ****************************************************************
    // Interrupt requests and wake-up.
    // ****************************************************************
    s_next.irq_s = s_next.start_f & s_next.ctl.start_ie;
    s_next.irq_w = s_next.wrap_f & s_next.ctl.wrap_ie;
    s_next.wake_all = s_next.irq_s;
    s_next.wake_idle = s_next.irq_s | s_next.irq_w;

    // ****************************************************************
    // Read data.
    // ****************************************************************
    ctl_rd = {s_reg.ctl, 2'h0};
    status_rd = {s_reg.start_f, s_reg.wrap_f, s_reg.stop_f, s_reg.shift[7] ^ sda, s_reg.cnt};
    if (accept & AVS_READ_IN) begin
      unique case (idx)
        USS_IDX_CONTROL: s_next.rdata = {24'h000000, ctl_rd};
        USS_IDX_STATUS: s_next.rdata = {24'h000000, status_rd};
        USS_IDX_SHIFT: s_next.rdata = {24'h000000, s_reg.shift};
        USS_IDX_BUFFER: s_next.rdata = {24'h000000, s_reg.rxbuf};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_reg <= USS_ST_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign AVS_READDATA_OUT = s_reg.rdata;
  assign AVS_WAITREQUEST_OUT = s_reg.wait_r;
  assign DATA_OUT_PIN_OUT = s_reg.do_o;
  assign DATA_OUT_OE_OUT = s_reg.do_oe;
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = s_reg.sda_oe;
  assign SCL_OUT = 1'b0;
  assign SCL_OE_OUT = s_reg.scl_oe;
  assign START_IRQ_OUT = s_reg.irq_s;
  assign WRAP_IRQ_OUT = s_reg.irq_w;
  assign WAKE_ALL_OUT = s_reg.wake_all;
  assign WAKE_IDLE_OUT = s_reg.wake_idle;

endmodule : uss_core

`default_nettype wire

// File: rtl/uss_pkg.sv
/*
  Constants and types for the universal serial shift core.
  Assumes a 125 MHz system clock and word-aligned Avalon-MM register access.
*/
package uss_pkg;

  // ****************************************************************
  // Bus and register map.
  // ****************************************************************
  localparam int USS_ADDR_W = 8;
  localparam int USS_DATA_W = 32;
  localparam logic [5:0] USS_IDX_CONTROL = 6'h0d;
  localparam logic [5:0] USS_IDX_STATUS = 6'h0e;
  localparam logic [5:0] USS_IDX_SHIFT = 6'h0f;
  localparam logic [5:0] USS_IDX_BUFFER = 6'h10;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int USS_CTL_START_IE = 7;
  localparam int USS_CTL_WRAP_IE = 6;
  localparam int USS_CTL_MODE_HI = 5;
  localparam int USS_CTL_MODE_LO = 4;
  localparam int USS_CTL_CSEL_HI = 3;
  localparam int USS_CTL_CSEL_LO = 2;
  localparam int USS_CTL_SHIFT_STB = 1;
  localparam int USS_CTL_TOGGLE_STB = 0;
  localparam int USS_STS_START = 7;
  localparam int USS_STS_WRAP = 6;
  localparam int USS_STS_STOP = 5;
  localparam int USS_STS_COLL = 4;

  // ****************************************************************
  // Encodings and reset values.
  // ****************************************************************
  localparam logic [1:0] USS_MODE_OFF = 2'h0;
  localparam logic [1:0] USS_MODE_THREE = 2'h1;
  localparam logic [1:0] USS_MODE_TWO_HOLD = 2'h3;
  localparam logic [1:0] USS_CSEL_SOFT = 2'h0;
  localparam logic [1:0] USS_CSEL_TIMER = 2'h1;
  localparam logic [1:0] USS_CSEL_EXT_RISE = 2'h2;
  localparam logic [1:0] USS_CSEL_EXT_FALL = 2'h3;
  localparam logic [3:0] USS_CNT_MAX = 4'hf;
  localparam logic [7:0] USS_BYTE_RESET = 8'h00;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int USS_CLK_PERIOD_NS = 8;
  localparam int USS_SDA_DELAY_MIN_NS = 50;
  localparam int USS_SDA_DELAY_MAX_NS = 300;
  localparam int USS_SDA_DELAY_CYC = (USS_SDA_DELAY_MIN_NS + USS_CLK_PERIOD_NS - 1) / USS_CLK_PERIOD_NS;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef struct packed {
    logic start_ie;
    logic wrap_ie;
    logic [1:0] mode;
    logic [1:0] csel;
  } uss_ctrl_t;

  typedef struct packed {
    uss_ctrl_t ctl;
    logic tc_count;
    logic [7:0] shift;
    logic [7:0] rxbuf;
    logic [3:0] cnt;
    logic start_f;
    logic wrap_f;
    logic stop_f;
    logic start_hold;
    logic out_latch;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic [USS_SDA_DELAY_CYC:0] sda_dly;
    logic wait_r;
    logic [USS_DATA_W-1:0] rdata;
    logic do_o;
    logic do_oe;
    logic sda_oe;
    logic scl_oe;
    logic irq_s;
    logic irq_w;
    logic wake_all;
    logic wake_idle;
  } uss_state_t;

  localparam uss_state_t USS_ST_RESET = '{wait_r: 1'b1, default: '0};

endpackage : uss_pkg

// File: dv/uss_chk.sv
/*
  Port checker for the serial shift core.
  Assumes it is bound onto uss_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_chk (
  // Clock, reset and bus.
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [uss_pkg::USS_DATA_W-1:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  // Pins and requests.
  input wire logic DATA_DIR_IN,
  input wire logic DATA_OUT_OE_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic SCL_OE_OUT,
  input wire logic START_IRQ_OUT,
  input wire logic WRAP_IRQ_OUT,
  input wire logic WAKE_ALL_OUT,
  input wire logic WAKE_IDLE_OUT
);
  import uss_pkg::*;
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_wait_one; !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT; endproperty
  a_wait_one: assert property (p_wait_one) else $error("Waitrequest low twice.");
  property p_wait_ans; (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("Request not answered.");
  property p_rd_high; !AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:8] == 24'h000000; endproperty
  a_rd_high: assert property (p_rd_high) else $error("Upper read data set.");
  property p_wake_all; WAKE_ALL_OUT == START_IRQ_OUT; endproperty
  a_wake_all: assert property (p_wake_all) else $error("Wake all differs.");
  property p_wake_idle; WAKE_IDLE_OUT == (START_IRQ_OUT || WRAP_IRQ_OUT); endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("Wake idle differs.");
  property p_dir; !DATA_DIR_IN |=> !DATA_OUT_OE_OUT && !SDA_OE_OUT; endproperty
  a_dir: assert property (p_dir) else $error("Output enabled without direction.");
  property p_one_mode; DATA_OUT_OE_OUT |-> !SDA_OE_OUT; endproperty
  a_one_mode: assert property (p_one_mode) else $error("Both outputs enabled.");
  property p_start_clr; $fell(START_IRQ_OUT) |-> $past(AVS_WRITE_IN, 1) || $past(AVS_WRITE_IN, 2); endproperty
  a_start_clr: assert property (p_start_clr) else $error("Start request fell alone.");
  property p_wrap_clr; $fell(WRAP_IRQ_OUT) |-> $past(AVS_WRITE_IN, 1) || $past(AVS_WRITE_IN, 2); endproperty
  a_wrap_clr: assert property (p_wrap_clr) else $error("Wrap request fell alone.");
  property p_hold_rel; $fell(SCL_OE_OUT) |-> $past(AVS_WRITE_IN, 1) || $past(AVS_WRITE_IN, 2); endproperty
  a_hold_rel: assert property (p_hold_rel) else $error("Clock hold released alone.");
  c_start: cover property ($rose(START_IRQ_OUT));
  c_wrap: cover property ($rose(WRAP_IRQ_OUT));
  c_hold: cover property ($rose(SCL_OE_OUT));
endmodule : uss_chk
bind uss_core uss_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .DATA_DIR_IN(DATA_DIR_IN), .DATA_OUT_OE_OUT(DATA_OUT_OE_OUT), .SDA_OE_OUT(SDA_OE_OUT), .SCL_OE_OUT(SCL_OE_OUT),
  .START_IRQ_OUT(START_IRQ_OUT), .WRAP_IRQ_OUT(WRAP_IRQ_OUT), .WAKE_ALL_OUT(WAKE_ALL_OUT),
  .WAKE_IDLE_OUT(WAKE_IDLE_OUT));
`default_nettype wire

// File: dv/uss_peer.sv
/*
  Serial bus peer driving the clock and data lines.
  Assumes pull-ups on both lines and open-drain pulls from the core.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_peer (
  // Pulls from the core.
  input wire logic sda_pull_in,
  input wire logic scl_pull_in,
  // Line levels.
  output logic sda_out,
  output logic scl_out
);
  logic sda_d = 1'b0;
  logic scl_d = 1'b1;
  assign sda_out = sda_d & ~sda_pull_in;
  assign scl_out = scl_d & ~scl_pull_in;
  task automatic drive(input logic s, input logic c);
    sda_d <= s;
    scl_d <= c;
    #62.5;
  endtask : drive
  task automatic send_bit(input logic b);
    drive(b, 1'b0);
    drive(b, 1'b1);
  endtask : send_bit
  task automatic start_cond;
    drive(1'b1, 1'b1);
    drive(1'b0, 1'b1);
    drive(1'b0, 1'b0);
  endtask : start_cond
  task automatic stop_cond;
    drive(1'b0, 1'b0);
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
  endtask : stop_cond
endmodule : uss_peer
`default_nettype wire

// File: dv/uss_core_tb.sv
/*
  Testbench for the serial shift core with register tasks and a line peer.
  Assumes the single-cycle waitrequest answer of the core.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_core_tb;
  import uss_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [USS_ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [USS_DATA_W-1:0] wdata = '0;
  logic [USS_DATA_W-1:0] rdata;
  logic waitreq, tm = 1'b0, dir = 1'b0, sda, scl, do_pin, do_oe, sda_oe, scl_oe, s_irq, w_irq, wk_all, wk_idle;
  int bad_count = 0;
  int comparisons = 0;
  logic [7:0] rx = 8'h3c;
  always #4 clk = ~clk;
  uss_core u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'h1), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .SERIAL_IN_PIN_IN(sda), .SERIAL_CLOCK_PIN_IN(scl), .DATA_OUT_PIN_OUT(do_pin),
    .DATA_OUT_OE_OUT(do_oe), .SDA_OUT(), .SDA_OE_OUT(sda_oe), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
    .TIMER_MATCH_IN(tm), .DATA_DIR_IN(dir), .START_IRQ_OUT(s_irq), .WRAP_IRQ_OUT(w_irq),
    .WAKE_ALL_OUT(wk_all), .WAKE_IDLE_OUT(wk_idle));
  uss_peer u_peer (.sda_pull_in(sda_oe), .scl_pull_in(scl_oe), .sda_out(sda), .scl_out(scl));
  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) bad_count++;
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask : wreg
  task automatic rchk(input string nm, input logic [5:0] idx, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, idx, 8'h00, q);
    chk(nm, q & m, exp);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ****************************************************************
  // Tests.
  // ****************************************************************
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(2);
    rchk("status", USS_IDX_STATUS, 8'hff, 8'h00);
    rchk("control", USS_IDX_CONTROL, 8'hff, 8'h00);
    rchk("shift", USS_IDX_SHIFT, 8'hff, 8'h00);
    rchk("buffer", USS_IDX_BUFFER, 8'hff, 8'h00);
    rchk("unmapped", 6'h20, 8'hff, 8'h00);
    u_peer.start_cond();
    u_peer.stop_cond();
    cyc(12);
    rchk("status off", USS_IDX_STATUS, 8'hff, 8'h10);
    wreg(USS_IDX_STATUS, 8'h0f);
    wreg(USS_IDX_SHIFT, 8'h81);
    wreg(USS_IDX_CONTROL, 8'h42);
    cyc(2);
    rchk("shift strobe", USS_IDX_SHIFT, 8'hff, 8'h03);
    rchk("buffer strobe", USS_IDX_BUFFER, 8'hff, 8'h03);
    rchk("status strobe", USS_IDX_STATUS, 8'hff, 8'h50);
    chk("wrap irq", {7'h00, w_irq}, 8'h01);
    chk("wake idle", {7'h00, wk_idle}, 8'h01);
    wreg(USS_IDX_STATUS, 8'h40);
    rchk("status clear", USS_IDX_STATUS, 8'hff, 8'h10);
    wreg(USS_IDX_CONTROL, 8'h08);
    wreg(USS_IDX_STATUS, 8'hef);
    u_peer.send_bit(1'b1);
    cyc(8);
    rchk("status ext", USS_IDX_STATUS, 8'hff, 8'hd1);
    rchk("shift ext", USS_IDX_SHIFT, 8'hff, 8'h07);
    wreg(USS_IDX_CONTROL, 8'h04);
    wreg(USS_IDX_STATUS, 8'hce);
    repeat (2) begin
      @(posedge clk);
      tm <= 1'b1;
      @(posedge clk);
      tm <= 1'b0;
    end
    cyc(2);
    rchk("status timer", USS_IDX_STATUS, 8'h4f, 8'h40);
    rchk("shift timer", USS_IDX_SHIFT, 8'hff, 8'h1f);
    dir <= 1'b1;
    wreg(USS_IDX_CONTROL, 8'h10);
    wreg(USS_IDX_SHIFT, 8'h80);
    cyc(2);
    chk("data oe", {7'h00, do_oe}, 8'h01);
    chk("data out high", {7'h00, do_pin}, 8'h01);
    wreg(USS_IDX_SHIFT, 8'h00);
    cyc(2);
    chk("data out low", {7'h00, do_pin}, 8'h00);
    wreg(USS_IDX_CONTROL, 8'h18);
    wreg(USS_IDX_STATUS, 8'hc0);
    for (int i = 7; i >= 0; i--) u_peer.send_bit(rx[i]);
    cyc(8);
    rchk("buffer rx", USS_IDX_BUFFER, 8'hff, 8'h3c);
    rchk("status rx", USS_IDX_STATUS, 8'hcf, 8'hc0);
    dir <= 1'b0;
    wreg(USS_IDX_CONTROL, 8'hbc);
    wreg(USS_IDX_STATUS, 8'he0);
    u_peer.start_cond();
    cyc(8);
    chk("clock hold", {7'h00, scl_oe}, 8'h01);
    chk("start irq", {7'h00, s_irq}, 8'h01);
    chk("wake all", {7'h00, wk_all}, 8'h01);
    wreg(USS_IDX_STATUS, 8'ha0);
    cyc(2);
    chk("clock release", {7'h00, scl_oe}, 8'h00);
    chk("start irq clear", {7'h00, s_irq}, 8'h00);
    u_peer.stop_cond();
    cyc(12);
    rchk("status stop", USS_IDX_STATUS, 8'he0, 8'h20);
    chk("stop no irq", {7'h00, s_irq}, 8'h00);
    wreg(USS_IDX_CONTROL, 8'h2e);
    wreg(USS_IDX_STATUS, 8'h0f);
    wreg(USS_IDX_CONTROL, 8'h2f);
    cyc(2);
    chk("no wrap hold", {7'h00, scl_oe}, 8'h00);
    rchk("status toggle", USS_IDX_STATUS, 8'h4f, 8'h40);
    dir <= 1'b1;
    wreg(USS_IDX_SHIFT, 8'h00);
    cyc(4);
    chk("data pull", {7'h00, sda_oe}, 8'h01);
    rchk("status drive", USS_IDX_STATUS, 8'h10, 8'h00);
    dir <= 1'b0;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    rchk("control reset", USS_IDX_CONTROL, 8'hff, 8'h00);
    rchk("status reset", USS_IDX_STATUS, 8'hef, 8'h00);
    wrap_up;
  end
endmodule : uss_core_tb
`default_nettype wire
